// ===== logic/serial_defs.vh
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_DATA 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_CONTROL 4'h8
`define ADDR_BAUD 4'hC
// ****************************************
// control fields
// ****************************************
`define CTL_TX_EN 0
`define CTL_RX_EN 1
`define CTL_NINE 2
`define CTL_BREAK 3
`define CTL_LONG_BRK 4
`define CTL_TX_INV 5
`define CTL_RX_INV 6
`define CTL_T8 7
`define CTL_RESET 8'h00
// ****************************************
// status fields
// ****************************************
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define ST_TC 6
`define ST_RX_FULL_FLAG 5
`define ST_OR 3
`define ST_NF 2
`define ST_FE 1
`define ST_R8 0
// ****************************************
// divider and frame lengths
// ****************************************
`define BAUD_RESET 13'h0001
`define BRK_LEN_SHORT 4'hA
`define BRK_LEN_LONG 4'hD
`define FRAME_LEN 4'hA
`endif

// ===== logic/async_serial_transceiver.v

`timescale 1ns/100ps

`include "serial_defs.vh"
module async_serial_transceiver (
  input wire mclk_in, // bus clock
  input wire rst_n_in, // sync reset, active low
  input wire [3:0] avs_address_in, // byte address
  input wire avs_read_in, // read strobe
  input wire avs_write_in, // write strobe
  input wire [31:0] avs_writedata_in, // write data
  input wire [3:0] avs_byteenable_in, // byte lanes
  output reg [31:0] avs_readdata_out, // read data
  output reg avs_waitrequest_out, // stall
  input wire rxd_in, // serial receive line
  output reg txd_out, // serial transmit line
  output reg txd_oe_out // transmitter owns the pin
);

  // ****************************************
  // bus slave
  // ****************************************
  reg [7:0] ctl;
  reg [12:0] baud_div;
  reg ack;
  reg status_armed;
  reg tx_buffer_empty_flag; // transmit buffer empty
  reg tc; // transmit complete
  reg rx_full_flag; // receive buffer full
  reg ovr; // receive overrun
  reg nf; // noise seen in last character
  reg fe; // framing error
  reg [8:0] rx_buf;
  reg [8:0] tx_buf;

  // one wait state: the answer comes in the cycle after the request
  wire req = (avs_read_in | avs_write_in) & ~ack;
  wire do_rd = avs_read_in & ack;
  wire do_wr = avs_write_in & ack;
  wire rd_data = do_rd && avs_address_in == `ADDR_DATA;
  wire rd_stat = do_rd && avs_address_in == `ADDR_STATUS;
  wire wr_data = do_wr && avs_address_in == `ADDR_DATA
    && avs_byteenable_in[0];
  wire wr_ctl = do_wr && avs_address_in == `ADDR_CONTROL
    && avs_byteenable_in[0];
  // the divisor takes either byte lane
  wire wr_baud = do_wr && avs_address_in == `ADDR_BAUD;
  wire wr_baud_lo = wr_baud && avs_byteenable_in[0];
  wire wr_baud_hi = wr_baud && avs_byteenable_in[1];
  wire [7:0] status_word = {tx_buffer_empty_flag, tc, rx_full_flag, 1'b0, ovr, nf, fe, rx_buf[8]};
  wire nine = ctl[`CTL_NINE];
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack <= req;
      avs_waitrequest_out <= ~req;
      // read data is captured with the answer and then held
      if (req && avs_read_in) begin
        case (avs_address_in)
          `ADDR_DATA: avs_readdata_out <= {24'h000000, rx_buf[7:0]};
          `ADDR_STATUS: avs_readdata_out <= {24'h000000, status_word};
          `ADDR_CONTROL: avs_readdata_out <= {24'h000000, ctl};
          `ADDR_BAUD: avs_readdata_out <= {19'h00000, baud_div};
          default: avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctl <= `CTL_RESET;
      baud_div <= `BAUD_RESET;
    end else begin
      if (wr_ctl)
        ctl <= avs_writedata_in[7:0];
      if (wr_baud_lo)
        baud_div[7:0] <= avs_writedata_in[7:0];
      if (wr_baud_hi)
        baud_div[12:8] <= avs_writedata_in[12:8];
    end
  end

  // ****************************************
  // baud generator
  // ****************************************
  reg [12:0] div_cnt;
  reg tick16;
  reg [3:0] tx_sub;

  wire tx_bit_tick = tick16 && tx_sub == 4'hF;
  // a divisor of zero stops the sample clock
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      div_cnt <= 13'h0000;
      tick16 <= 1'b0;
      tx_sub <= 4'h0;
    end else begin
      tick16 <= 1'b0;
      if (baud_div != 13'h0000) begin
        if (div_cnt >= baud_div - 13'h0001) begin
          div_cnt <= 13'h0000;
          tick16 <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 13'h0001;
        end
      end
      if (tick16)
        tx_sub <= tx_sub + 4'h1;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  localparam TX_IDLE = 2'h0;
  localparam TX_BUSY = 2'h1;

  reg [1:0] tx_state;
  reg [10:0] tx_shift;
  reg [3:0] tx_left;
  reg tx_en_d;
  reg idle_q; // idle frame queued
  reg brk_q; // break queued
  reg brk_prev; // last send-break bit, for its falling edge
  reg tx_level;

  wire tx_en = ctl[`CTL_TX_EN];
  wire brk_now = ctl[`CTL_BREAK];
  wire [3:0] frame_len = `FRAME_LEN + {3'h0, nine};
  wire [3:0] brk_len = (ctl[`CTL_LONG_BRK] ? `BRK_LEN_LONG : `BRK_LEN_SHORT)
    + {3'h0, nine};
  // the shifter frees on the tick after its last bit
  wire tx_free = tx_state == TX_IDLE || tx_left == 4'h0;

  // ****************************************
  // transmit sequencer
  // ****************************************
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      tx_en_d <= 1'b0;
      idle_q <= 1'b0;
      brk_q <= 1'b0;
      brk_prev <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
      tc <= 1'b1;
      tx_buf <= 9'h000;
      tx_level <= 1'b1;
    end else begin
      tx_en_d <= tx_en;
      brk_prev <= brk_now;
      // a rising enable, first or after a clear, queues one idle frame
      if (tx_en && !tx_en_d)
        idle_q <= 1'b1;
      if (!brk_now && brk_prev)
        brk_q <= 1'b1;
      // a data write while the buffer is full is dropped
      if (wr_data && tx_buffer_empty_flag) begin
        tx_buf <= {ctl[`CTL_T8], avs_writedata_in[7:0]};
        tx_buffer_empty_flag <= 1'b0;
        tc <= 1'b0;
      end
      if (tx_bit_tick) begin
        if (tx_state == TX_BUSY && tx_left != 4'h0) begin
          tx_level <= tx_shift[0];
          // the top bit refills, so a break stays low to its end
          tx_shift <= {tx_shift[10], tx_shift[10:1]};
          tx_left <= tx_left - 4'h1;
        end
        if (tx_free) begin
          // a queued preamble leaves before a queued break
          if (idle_q) begin
            tx_shift <= 11'h7FF;
            tx_level <= 1'b1;
            tx_left <= frame_len - 4'h1;
            tx_state <= TX_BUSY;
            idle_q <= 1'b0;
          end else if (brk_q || (brk_now && tx_state == TX_BUSY
              && tx_shift == 11'h000 && tx_en)) begin
            tx_shift <= 11'h000;
            tx_level <= 1'b0;
            tx_left <= brk_len - 4'h1;
            tx_state <= TX_BUSY;
            brk_q <= brk_now;
          end else if (!tx_buffer_empty_flag && tx_en) begin
            if (nine)
              tx_shift <= {1'b1, 1'b1, tx_buf};
            else
              tx_shift <= {2'h3, 1'b1, tx_buf[7:0]};
            tx_level <= 1'b0;
            tx_left <= frame_len - 4'h1;
            tx_state <= TX_BUSY;
            tx_buffer_empty_flag <= 1'b1;
          end else begin
            tx_state <= TX_IDLE;
            tx_level <= 1'b1;
            if (tx_state == TX_BUSY)
              tc <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // the pin stays owned until queued idle and break frames are out
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      txd_out <= 1'b1;
      txd_oe_out <= 1'b0;
    end else begin
      txd_out <= tx_level ^ ctl[`CTL_TX_INV];
      txd_oe_out <= tx_en || tx_state == TX_BUSY || idle_q || brk_q;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  localparam RX_HUNT = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;

  reg [1:0] rx_state;
  reg [2:0] hist;
  reg [3:0] rt;
  reg [3:0] bit_idx;
  reg [2:0] votes;
  reg [9:0] rx_shift;
  reg noisy;

  wire rx_s = rxd_in ^ ctl[`CTL_RX_INV];
  // an edge is a zero sample after three ones
  wire edge_seen = hist == 3'h7 && !rx_s;
  // the stop bit comes after the start bit and all data bits
  wire [3:0] last_idx = 4'h9 + {3'h0, nine};
  wire [8:0] rx_word = nine ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
  wire rx_is_break = rx_word == 9'h000;
  // two of three votes decide a level
  wire maj = (votes[0] & votes[1]) | (votes[0] & rx_s) | (votes[1] & rx_s);
  wire disagree = (votes[0] != maj) || (votes[1] != maj) || (rx_s != maj);
  // the start bit level is fixed at zero by its earlier validation
  wire bit_level = bit_idx != 4'h0 && maj;
  wire bit_noise = (votes[0] != bit_level) || (votes[1] != bit_level)
    || (rx_s != bit_level);

  // ****************************************
  // receive framing
  // ****************************************
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rx_state <= RX_HUNT;
      hist <= 3'h0;
      rt <= 4'h0;
      bit_idx <= 4'h0;
      votes <= 3'h0;
      rx_shift <= 10'h000;
      noisy <= 1'b0;
      rx_buf <= 9'h000;
      rx_full_flag <= 1'b0;
      ovr <= 1'b0;
      nf <= 1'b0;
      fe <= 1'b0;
      status_armed <= 1'b0;
    end else begin
      // flags clear by a status read that saw one set, then a data read
      if (rd_stat)
        status_armed <= rx_full_flag | ovr | nf | fe;
      if (rd_data && status_armed) begin
        rx_full_flag <= 1'b0;
        ovr <= 1'b0;
        nf <= 1'b0;
        fe <= 1'b0;
        status_armed <= 1'b0;
      end
      if (tick16 && ctl[`CTL_RX_EN]) begin
        hist <= {hist[1:0], rx_s};
        rt <= rt + 4'h1;
        if (edge_seen) begin
          rt <= 4'h2;
          if (rx_state == RX_HUNT) begin
            rx_state <= RX_START;
            votes <= 3'h0;
            noisy <= 1'b0;
          end
        end
        // an edge sets phase two, so the edge sample counts as phase one
        case (rx_state)
          RX_START: begin
            if (rt == 4'h3)
              votes[0] <= rx_s;
            if (rt == 4'h5)
              votes[1] <= rx_s;
            if (rt == 4'h7) begin
              if (maj) begin
                rx_state <= RX_HUNT;
              end else begin
                noisy <= disagree;
                rx_state <= RX_DATA;
                bit_idx <= 4'h0;
              end
            end
            if (rt == 4'h9 || rt == 4'hA)
              noisy <= noisy | rx_s;
          end
          RX_DATA: begin
            if (rt == 4'h8)
              votes[0] <= rx_s;
            if (rt == 4'h9)
              votes[1] <= rx_s;
            if (rt == 4'hA) begin
              noisy <= noisy | bit_noise;
              rx_shift <= {bit_level, rx_shift[9:1]};
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx == last_idx) begin
                rx_state <= RX_HUNT;
                if (!fe) begin
                  if (rx_full_flag) begin
                    // buffer still full: the new character is lost
                    ovr <= 1'b1;
                  end else begin
                    rx_full_flag <= 1'b1;
                    nf <= noisy | bit_noise;
                    fe <= !maj;
                    rx_buf <= rx_word;
                  end
                end
                if (!maj && !rx_is_break)
                  hist <= 3'h7;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule // async_serial_transceiver

// ===== test/serial_port_props.sv
`timescale 1ns/100ps
module serial_port_props (
  input wire mclk_in, // bus clock
  input wire rst_n_in, // sync reset
  input wire [3:0] avs_address_in, // byte address
  input wire avs_read_in, // read strobe
  input wire avs_write_in, // write strobe
  input wire [31:0] avs_readdata_out, // read data
  input wire avs_waitrequest_out, // stall
  input wire txd_out, // tx line
  input wire txd_oe_out // tx owns pin
);
  // ****
  // port timing
  // ****
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  answer_time_a: assert property ($rose(avs_read_in || avs_write_in)
    |=> !avs_waitrequest_out) else $error("late bus answer");
  wait_one_a: assert property (!avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("waitrequest low too long");
  wait_cause_a: assert property (!avs_waitrequest_out
    |-> avs_read_in || avs_write_in) else $error("answer without request");
  unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  readdata_hold_a: assert property ($changed(avs_readdata_out)
    |-> avs_read_in && !avs_waitrequest_out) else $error("readdata moved");
  reset_idle_a: assert property ($rose(rst_n_in)
    |-> txd_out && !txd_oe_out) else $error("tx line not idle in reset");
  preamble_idle_a: assert property ($rose(txd_oe_out)
    |-> txd_out [*8]) else $error("no idle preamble");
  bit_hold_a: assert property ($changed(txd_out) && txd_oe_out
    |=> $stable(txd_out) [*8]) else $error("tx bit too short");
endmodule // serial_port_props
bind async_serial_transceiver serial_port_props serial_port_props_i (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .txd_out(txd_out),
  .txd_oe_out(txd_oe_out));

// ===== test/serial_line_partner.sv
`timescale 1ns/100ps
module serial_line_partner (
  input wire mclk_in, // bus clock, 16 per bit
  input wire line_in, // device transmit line
  output reg line_out // device receive line
);
  integer nb = 8;
  integer n_got = 0;
  integer run = 0;
  integer low_len = 0;
  reg [8:0] got = 9'h000;
  reg [8:0] sh;
  integer i;
  // ****
  // decoder and low-run meter
  // ****
  initial line_out = 1'b1;
  always @(posedge mclk_in) begin
    if (!line_in)
      run <= run + 1;
    else begin
      if (run != 0)
        low_len <= run;
      run <= 0;
    end
  end
  initial forever begin
    @(posedge mclk_in iff line_in === 1'b0);
    repeat (8) @(posedge mclk_in);
    sh = 9'h000;
    for (i = 0; i < nb; i = i + 1) begin
      repeat (16) @(posedge mclk_in);
      sh[i] = line_in;
    end
    repeat (24) @(posedge mclk_in);
    got = sh;
    n_got = n_got + 1;
  end
  // start, n data bits lsb first, stop; g picks a bit glitched once
  task send(input [8:0] v, input integer n, input stp, input integer g);
    integer b;
    integer j;
    reg lvl;
    begin
      for (b = 0; b < n + 2; b = b + 1) begin
        lvl = (b == 0) ? 1'b0 : (b > n) ? stp : v[b - 1];
        for (j = 0; j < 16; j = j + 1) begin
          @(posedge mclk_in);
          line_out <= (b == g + 1 && j == 8) ? ~lvl : lvl;
        end
      end
      @(posedge mclk_in);
      line_out <= 1'b1;
    end
  endtask
endmodule // serial_line_partner

// ===== test/async_serial_transceiver_tb_top.sv
`timescale 1ns/100ps
`include "serial_defs.vh"
module async_serial_transceiver_tb_top;
  reg mclk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg [3:0] avs_address_in = 4'h0;
  reg avs_read_in = 1'b0;
  reg avs_write_in = 1'b0;
  reg [31:0] avs_writedata_in = 32'h0;
  reg [3:0] avs_byteenable_in = 4'hF;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out;
  wire rxd_in;
  wire txd_out;
  wire txd_oe_out;
  wire line = txd_oe_out ? txd_out : 1'b1;
  integer fails = 0;
  integer n_checks = 0;
  integer k;
  reg [31:0] rd;
  async_serial_transceiver async_serial_transceiver_i (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe_out(txd_oe_out));
  serial_line_partner serial_line_partner_i (
    .mclk_in(mclk_in), .line_in(line), .line_out(rxd_in));
  initial forever #2 mclk_in = ~mclk_in;
  // ****
  // shared tasks
  // ****
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0)
        @(posedge mclk_in);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
    end
  endtask
  task poll(input integer b);
    integer w;
    begin
      rd = 32'h0;
      for (w = 0; w < 2000 && rd[b] !== 1'b1; w = w + 1)
        bus(0, `ADDR_STATUS, 0);
    end
  endtask
  task wait_line(input integer n);
    for (k = 0; k < 4000 && serial_line_partner_i.n_got < n; k = k + 1)
      @(posedge mclk_in);
  endtask
  task rx_flags(input [31:0] st, input [31:0] dat);
    begin
      poll(`ST_RX_FULL_FLAG);
      chk(rd & 32'h2E, st);
      bus(0, `ADDR_DATA, 0);
      chk(rd, dat);
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    begin
      chk({31'h0, txd_out}, 32'h1);
      bus(0, 4'h1, 0);
      chk(rd, 32'h0);
      bus(1, `ADDR_CONTROL, 32'h20);
      repeat (2) @(posedge mclk_in);
      chk({31'h0, txd_out}, 32'h0);
      bus(1, `ADDR_CONTROL, 32'h0);
      bus(1, `ADDR_BAUD, 32'h1);
      $display("t_regs done");
    end
  endtask
  task t_tx;
    begin
      bus(1, `ADDR_CONTROL, 32'h03);
      bus(0, `ADDR_STATUS, 0);
      bus(1, `ADDR_DATA, 32'hA5);
      poll(`ST_TX_BUFFER_EMPTY_FLAG);
      bus(1, `ADDR_DATA, 32'h3C);
      wait_line(1);
      chk(serial_line_partner_i.got, 32'hA5);
      bus(1, `ADDR_CONTROL, 32'h02);
      chk({31'h0, txd_oe_out}, 32'h1);
      wait_line(2);
      chk(serial_line_partner_i.got, 32'h3C);
      bus(0, `ADDR_STATUS, 0);
      chk({31'h0, rd[`ST_TC]}, 32'h1);
      chk({31'h0, txd_oe_out}, 32'h0);
      $display("t_tx done");
    end
  endtask
  task t_nine;
    begin
      serial_line_partner_i.nb = 9;
      bus(1, `ADDR_CONTROL, 32'h87);
      bus(0, `ADDR_STATUS, 0);
      bus(1, `ADDR_DATA, 32'h5A);
      wait_line(3);
      chk(serial_line_partner_i.got, 32'h15A);
      serial_line_partner_i.send(9'h1C3, 9, 1'b1, 99);
      poll(`ST_RX_FULL_FLAG);
      chk({31'h0, rd[`ST_R8]}, 32'h1);
      bus(0, `ADDR_DATA, 0);
      chk(rd, 32'hC3);
      bus(1, `ADDR_CONTROL, 32'h02);
      serial_line_partner_i.nb = 8;
      $display("t_nine done");
    end
  endtask
  task t_rx;
    begin
      serial_line_partner_i.send(9'h096, 8, 1'b1, 0);
      rx_flags(32'h24, 32'h96);
      bus(0, `ADDR_STATUS, 0);
      chk(rd & 32'h2E, 32'h0);
      serial_line_partner_i.send(9'h011, 8, 1'b1, 99);
      serial_line_partner_i.send(9'h022, 8, 1'b1, 99);
      rx_flags(32'h28, 32'h11);
      serial_line_partner_i.send(9'h055, 8, 1'b0, 99);
      rx_flags(32'h22, 32'h55);
      rx_flags(32'h24, 32'hFF);
      serial_line_partner_i.send(9'h000, 8, 1'b0, 99);
      rx_flags(32'h22, 32'h00);
      $display("t_rx done");
    end
  endtask
  task t_brk;
    integer c;
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) begin
        c = 32'h0B | ((j & 1) << 2) | ((j & 2) << 3);
        serial_line_partner_i.low_len = 0;
        bus(1, `ADDR_CONTROL, c);
        bus(1, `ADDR_CONTROL, c & 32'hF7);
        for (k = 0; k < 2000 && serial_line_partner_i.low_len == 0; k++)
          @(posedge mclk_in);
        chk(serial_line_partner_i.low_len, 16 * (10 + (j & 1) + (j & 2) * 3 / 2));
      end
      $display("t_brk done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_tx;
    t_nine;
    t_rx;
    t_brk;
    give_verdict;
  end
  initial begin
    #300000;
    fails = fails + 1;
    give_verdict;
  end
endmodule // async_serial_transceiver_tb_top
